/* design/cdr_params.svh */
`ifndef CDR_PARAMS_SVH
`define CDR_PARAMS_SVH

// Register byte offsets
`define CDR_OFF_CTRL 8'h00
`define CDR_OFF_THRESH 8'h04
`define CDR_OFF_STATUS 8'h08
`define CDR_OFF_IRQ_STAT 8'h0C
`define CDR_OFF_IRQ_MASK 8'h10
`define CDR_OFF_MEAS 8'h14

// Control register fields
`define CDR_CTRL_MANUAL 0
`define CDR_CTRL_PIPE 1
`define CDR_CTRL_CODEC 2
`define CDR_CTRL_PLL_SEL 3
`define CDR_CTRL_SOFT_RST 4
`define CDR_CTRL_W 5
`define CDR_CTRL_RST 5'h04

// Status register fields
`define CDR_STAT_DATA_LOCKED 0
`define CDR_STAT_FREQ_LOCKED 1
`define CDR_STAT_SIG_PRESENT 2
`define CDR_STAT_IN_THRESH 3
`define CDR_STAT_MEAS_VALID 4

// Interrupt event bits
`define CDR_IRQ_LOCK_GAIN 0
`define CDR_IRQ_LOCK_LOSS 1
`define CDR_IRQ_SIG_GAIN 2
`define CDR_IRQ_SIG_LOSS 3
`define CDR_IRQ_W 4

// Frequency comparison
`define CDR_CNT_W 16
`define CDR_WIN 16'h0400
`define CDR_THRESH_RST 16'h0002

`define CDR_RESP_OKAY 2'h0
`define CDR_RESP_SLVERR 2'h2

`endif

/* design/cdr_pkg.sv */
package cdr_pkg;

  typedef enum logic [0:0]
  {
    cdr_ref_locked_state = 1'h0,
    cdr_data_locked_state = 1'h1
  } cdr_state_t;

endpackage : cdr_pkg

/* design/cdr_ppm_meter.sv */
`timescale 1ns/10ps
`include "cdr_params.svh"

// Counts recovered-clock edges over a window of reference edges
module cdr_ppm_meter
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic ref_edge,
  input wire logic rec_edge,
  input wire logic [`CDR_CNT_W-1:0] thresh,
  output logic in_thresh,
  output logic meas_valid,
  output logic [`CDR_CNT_W-1:0] diff
);

  logic [`CDR_CNT_W-1:0] win_cnt_q;
  logic [`CDR_CNT_W-1:0] rec_cnt_q;
  logic [`CDR_CNT_W-1:0] rec_total;
  logic [`CDR_CNT_W-1:0] diff_now;
  logic win_end;
  logic rec_full;

  assign win_end = ref_edge && (win_cnt_q == `CDR_WIN - 16'h0001);
  assign rec_full = &rec_cnt_q;
  assign rec_total = (rec_edge && !rec_full) ? rec_cnt_q + 16'h0001 : rec_cnt_q;
  assign diff_now = (rec_total >= `CDR_WIN) ? rec_total - `CDR_WIN : `CDR_WIN - rec_total;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      win_cnt_q <= '0;
      rec_cnt_q <= '0;
    end
    else if (win_end)
    begin
      win_cnt_q <= '0;
      rec_cnt_q <= '0;
    end
    else
    begin
      win_cnt_q <= ref_edge ? win_cnt_q + 16'h0001 : win_cnt_q;
      rec_cnt_q <= rec_total;
    end
  end

  // Nothing counts as in range until a full window has been seen
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      in_thresh <= 1'b0;
      meas_valid <= 1'b0;
      diff <= '0;
    end
    else if (win_end)
    begin
      in_thresh <= (diff_now <= thresh);
      meas_valid <= 1'b1;
      diff <= diff_now;
    end
  end

endmodule : cdr_ppm_meter

/* design/cdr_lock_ctrl.sv */
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "cdr_params.svh"

module cdr_lock_ctrl
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rec_clk,
  input wire logic pll0_clk,
  input wire logic pll1_clk,
  input wire logic sig_above_hi,
  input wire logic sig_above_lo,
  input wire logic lock_to_ref,
  input wire logic lock_to_data,
  output logic pd_enable,
  output logic freq_locked,
  output logic sig_present,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  function automatic logic [31:0] merge_bytes
  (
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // Input synchronisers; stage 1 feeds only stage 2
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic rec_s3_q;
  logic ref_s3_q;

  // Register file
  logic [`CDR_CTRL_W-1:0] ctrl_q;
  logic [`CDR_CNT_W-1:0] thresh_q;
  logic [`CDR_IRQ_W-1:0] irq_stat_q;
  logic [`CDR_IRQ_W-1:0] irq_mask_q;

  // Lock state
  cdr_pkg::cdr_state_t state_q;
  cdr_pkg::cdr_state_t state_d;
  logic sig_det_q;
  logic sig_det_d;

  // Bus slave state
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Synchronised view of the pins
  wire rec_s2 = sync2_q[0];
  wire pll0_s2 = sync2_q[1];
  wire pll1_s2 = sync2_q[2];
  wire hi_s2 = sync2_q[3];
  wire lo_s2 = sync2_q[4];
  wire force_ref_s2 = sync2_q[5];
  wire force_data_s2 = sync2_q[6];

  wire manual_en = ctrl_q[`CDR_CTRL_MANUAL];
  wire pipe_mode = ctrl_q[`CDR_CTRL_PIPE];
  wire codec_en = ctrl_q[`CDR_CTRL_CODEC];
  wire pll_sel = ctrl_q[`CDR_CTRL_PLL_SEL];
  wire soft_rst = ctrl_q[`CDR_CTRL_SOFT_RST];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {lock_to_data, lock_to_ref, sig_above_lo, sig_above_hi,
                  pll1_clk, pll0_clk, rec_clk};
      sync2_q <= sync1_q;
    end
  end

  // Reference source selected among the two PLL clocks
  wire ref_s2 = pll_sel ? pll1_s2 : pll0_s2;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rec_s3_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end
    else
    begin
      rec_s3_q <= rec_s2;
      ref_s3_q <= ref_s2;
    end
  end

  wire rec_edge = rec_s2 && !rec_s3_q;
  wire ref_edge = ref_s2 && !ref_s3_q;

  // Switching the PLL mid-window would mix two references
  logic pll_sel_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_sel_q <= 1'b0;
    end
    else
    begin
      pll_sel_q <= pll_sel;
    end
  end

  wire meas_clear = soft_rst || (pll_sel != pll_sel_q);

  logic in_thresh;
  logic meas_valid;
  logic [`CDR_CNT_W-1:0] meas_diff;

  // One meter per channel instance, nothing shared
  cdr_ppm_meter u_meter
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(meas_clear),
    .ref_edge(ref_edge),
    .rec_edge(rec_edge),
    .thresh(thresh_q),
    .in_thresh(in_thresh),
    .meas_valid(meas_valid),
    .diff(meas_diff)
  );

  // Signal presence with two comparator levels
  always_comb
  begin
    if (!codec_en)
    begin
      sig_det_d = 1'b1;
    end
    else if (hi_s2)
    begin
      sig_det_d = 1'b1;
    end
    else if (!lo_s2)
    begin
      sig_det_d = 1'b0;
    end
    else
    begin
      sig_det_d = sig_det_q;
    end
  end

  // Signal presence gates automatic moves only in PIPE mode
  wire sig_ok = !pipe_mode || sig_det_q;
  wire auto_up = in_thresh && sig_ok;
  wire auto_down = !in_thresh || !sig_ok;
  wire manual_ref = manual_en && force_ref_s2;
  wire manual_data = manual_en && force_data_s2 && !force_ref_s2;

  always_comb
  begin
    state_d = state_q;
    if (soft_rst)
    begin
      state_d = cdr_pkg::cdr_ref_locked_state;
    end
    else if (manual_ref)
    begin
      state_d = cdr_pkg::cdr_ref_locked_state;
    end
    else if (manual_data)
    begin
      state_d = cdr_pkg::cdr_data_locked_state;
    end
    else
    begin
      // Automatic when manual is off or neither input is set
      case (state_q)
        cdr_pkg::cdr_ref_locked_state:
        begin
          if (auto_up)
          begin
            state_d = cdr_pkg::cdr_data_locked_state;
          end
        end
        cdr_pkg::cdr_data_locked_state:
        begin
          if (auto_down)
          begin
            state_d = cdr_pkg::cdr_ref_locked_state;
          end
        end
        default:
        begin
          state_d = cdr_pkg::cdr_ref_locked_state;
        end
      endcase
    end
  end

  wire going_data = state_d == cdr_pkg::cdr_data_locked_state;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= cdr_pkg::cdr_ref_locked_state;
      pd_enable <= 1'b0;
      freq_locked <= 1'b0;
      sig_det_q <= 1'b1;
      sig_present <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      pd_enable <= going_data;
      freq_locked <= going_data;
      sig_det_q <= sig_det_d;
      sig_present <= sig_det_d;
    end
  end

  // Events for the interrupt status
  wire lock_gain = (state_q == cdr_pkg::cdr_ref_locked_state) && going_data;
  wire lock_loss = (state_q == cdr_pkg::cdr_data_locked_state) && !going_data;
  wire [`CDR_IRQ_W-1:0] irq_events = {!sig_det_d && sig_det_q, sig_det_d && !sig_det_q,
                                      lock_loss, lock_gain};

  // Write channel
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  wire aw_full_d = (aw_full_q || aw_hs) && !wr_go;
  wire w_full_d = (w_full_q || w_hs) && !wr_go;
  wire bvalid_d = wr_go || (s_axi_bvalid && !s_axi_bready);

  wire wr_ctrl = wr_go && (aw_addr_q == `CDR_OFF_CTRL);
  wire wr_thresh = wr_go && (aw_addr_q == `CDR_OFF_THRESH);
  wire wr_stat = wr_go && (aw_addr_q == `CDR_OFF_IRQ_STAT);
  wire wr_mask = wr_go && (aw_addr_q == `CDR_OFF_IRQ_MASK);
  wire wr_ro = (aw_addr_q == `CDR_OFF_STATUS) || (aw_addr_q == `CDR_OFF_MEAS);
  wire wr_hit = wr_ctrl || wr_thresh || wr_stat || wr_mask || wr_ro;

  wire [31:0] ctrl_new = merge_bytes({27'h0000000, ctrl_q}, w_data_q, w_strb_q);
  wire [31:0] thresh_new = merge_bytes({16'h0000, thresh_q}, w_data_q, w_strb_q);
  wire [31:0] mask_new = merge_bytes({28'h0000000, irq_mask_q}, w_data_q, w_strb_q);
  wire [31:0] clr_bits = merge_bytes(32'h00000000, w_data_q, w_strb_q);

  // A new event wins over a clear in the same cycle
  wire [`CDR_IRQ_W-1:0] stat_kept = wr_stat ? irq_stat_q & ~clr_bits[`CDR_IRQ_W-1:0]
                                            : irq_stat_q;
  wire [`CDR_IRQ_W-1:0] irq_stat_d = stat_kept | irq_events;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CDR_RESP_OKAY;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      s_axi_awready <= !aw_full_d;
      s_axi_wready <= !w_full_d;
      s_axi_bvalid <= bvalid_d;
      if (aw_hs)
      begin
        aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (w_hs)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        s_axi_bresp <= wr_hit ? `CDR_RESP_OKAY : `CDR_RESP_SLVERR;
      end
    end
  end

  // Soft reset bit clears itself after one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `CDR_CTRL_RST;
      thresh_q <= `CDR_THRESH_RST;
      irq_mask_q <= '0;
      irq_stat_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      ctrl_q <= wr_ctrl ? ctrl_new[`CDR_CTRL_W-1:0]
                        : (ctrl_q & ~(5'h01 << `CDR_CTRL_SOFT_RST));
      thresh_q <= wr_thresh ? thresh_new[`CDR_CNT_W-1:0] : thresh_q;
      irq_mask_q <= wr_mask ? mask_new[`CDR_IRQ_W-1:0] : irq_mask_q;
      irq_stat_q <= irq_stat_d;
      irq <= |(irq_stat_d & (wr_mask ? mask_new[`CDR_IRQ_W-1:0] : irq_mask_q));
    end
  end

  // Read channel
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire rvalid_d = rd_go || (s_axi_rvalid && !s_axi_rready);
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'h0};

  wire [31:0] status_word = {27'h0000000, meas_valid, in_thresh, sig_det_q, freq_locked,
                             state_q == cdr_pkg::cdr_data_locked_state};

  logic [31:0] rd_mux;
  logic rd_hit;

  always_comb
  begin
    rd_hit = 1'b1;
    case (rd_addr)
      `CDR_OFF_CTRL: rd_mux = {27'h0000000, ctrl_q};
      `CDR_OFF_THRESH: rd_mux = {16'h0000, thresh_q};
      `CDR_OFF_STATUS: rd_mux = status_word;
      `CDR_OFF_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
      `CDR_OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
      `CDR_OFF_MEAS: rd_mux = {16'h0000, meas_diff};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CDR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (rd_go)
      begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `CDR_RESP_OKAY : `CDR_RESP_SLVERR;
      end
    end
  end

endmodule : cdr_lock_ctrl

/* test/cdr_lock_ctrl_properties.sv */
`timescale 1ns/10ps
module cdr_lock_ctrl_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sig_above_hi,
  input wire logic sig_above_lo,
  input wire logic pd_enable,
  input wire logic freq_locked,
  input wire logic sig_present,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_PD_FL: assert property (pd_enable == freq_locked)
    else $error("phase detector enable and frequency lock differ");
  AST_RST: assert property (disable iff (1'b0) !aresetn |=> !pd_enable && !freq_locked)
    else $error("lock seen right after reset");
  AST_SIG_HI: assert property (sig_above_hi [*5] |=> sig_present)
    else $error("strong level without signal presence");
  AST_SIG_HOLD: assert property ((sig_above_lo && !sig_above_hi) [*5] |=> $stable(sig_present))
    else $error("presence moved inside hysteresis band");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule : cdr_lock_ctrl_chk

/* test/cdr_tx_model.sv */
`timescale 1ns/10ps
module cdr_tx_model
(
  input wire logic [1:0] level,
  output logic rec_clk,
  output logic sig_above_hi,
  output logic sig_above_lo
);
  // Recovered clock runs free, as the loop output would
  initial
  begin
    rec_clk = 1'b0;
    forever #62.5 rec_clk = ~rec_clk;
  end
  // Level 0 absent, 1 inside hysteresis band, 2 strong
  assign sig_above_hi = (level == 2'h2);
  assign sig_above_lo = (level != 2'h0);
endmodule : cdr_tx_model

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic aclk, aresetn, pll0_clk, pll1_clk, lock_to_ref, lock_to_data, rec_clk, irq;
  logic sig_above_hi, sig_above_lo, pd_enable, freq_locked, sig_present;
  logic [1:0] level, rr;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  cdr_tx_model i_cdr_tx_model (.level, .rec_clk, .sig_above_hi, .sig_above_lo);
  cdr_lock_ctrl i_cdr_lock_ctrl (.aclk, .aresetn, .rec_clk, .pll0_clk, .pll1_clk, .sig_above_hi,
    .sig_above_lo, .lock_to_ref, .lock_to_data, .pd_enable, .freq_locked, .sig_present, .irq,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Same rate as the link, so one window lands inside the threshold
  initial
  begin
    pll0_clk = 1'b0;
    forever #62.5 pll0_clk = ~pll0_clk;
  end
  initial
  begin
    pll1_clk = 1'b0;
    #20;
    forever #62.5 pll1_clk = ~pll1_clk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  // One window is about 32000 cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 70000)
    begin
      fails++;
      conclude();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr
  task axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd
  task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    axi_rd(a);
    chk(rd, e);
    chk({30'h0, rr}, {30'h0, er});
  endtask : rd_chk
  task fl(input logic e);
    chk({30'h0, pd_enable, freq_locked}, {30'h0, e, e});
  endtask : fl
  task step(input logic [1:0] lv, input logic e);
    level <= lv;
    repeat (8) @(posedge aclk);
    fl(e);
  endtask : step
  initial
  begin
    {aresetn, lock_to_ref, lock_to_data, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd} = 80'h0;
    s_axi_wstrb = 4'hF;
    level = 2'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    fl(1'b0);
    rd_chk(8'h00, 32'h4, 2'h0);
    rd_chk(8'h04, 32'h2, 2'h0);
    rd_chk(8'h10, 32'h0, 2'h0);
    rd_chk(8'h18, 32'h0, 2'h2);
    axi_wr(8'h18, 32'h0);
    chk({30'h0, rr}, 32'h2);
    $display("test registers done");
    axi_wr(8'h00, 32'h6);
    chk({30'h0, rr}, 32'h0);
    step(2'h0, 1'b0);
    chk({31'h0, sig_present}, 32'h0);
    for (int i = 0; i < 12000 && rd[3] !== 1'b1; i++)
      axi_rd(8'h08);
    fl(1'b0);
    step(2'h1, 1'b0);
    chk({31'h0, sig_present}, 32'h0);
    step(2'h2, 1'b1);
    rd_chk(8'h08, 32'h1F, 2'h0);
    chk({31'h0, irq}, 32'h0);
    rd_chk(8'h0C, 32'hD, 2'h0);
    axi_wr(8'h10, 32'h1);
    chk({31'h0, irq}, 32'h1);
    axi_wr(8'h0C, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd_chk(8'h0C, 32'hC, 2'h0);
    step(2'h1, 1'b1);
    step(2'h0, 1'b0);
    step(2'h2, 1'b1);
    axi_wr(8'h00, 32'h4);
    step(2'h0, 1'b1);
    axi_wr(8'h00, 32'hC);
    step(2'h0, 1'b0);
    $display("test automatic lock done");
    axi_wr(8'h00, 32'h5);
    lock_to_data <= 1'b1;
    step(2'h0, 1'b1);
    lock_to_ref <= 1'b1;
    step(2'h0, 1'b0);
    {lock_to_ref, lock_to_data} <= 2'h0;
    step(2'h0, 1'b0);
    axi_wr(8'h00, 32'h0);
    step(2'h0, 1'b0);
    chk({31'h0, sig_present}, 32'h1);
    $display("test manual lock done");
    axi_wr(8'h00, 32'h1);
    lock_to_data <= 1'b1;
    step(2'h0, 1'b1);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    fl(1'b0);
    {aresetn, lock_to_data} <= 2'h2;
    @(posedge aclk);
    rd_chk(8'h00, 32'h4, 2'h0);
    $display("test second reset done");
    conclude();
  end
endmodule : tb_top
bind cdr_lock_ctrl cdr_lock_ctrl_chk i_cdr_lock_ctrl_chk (.aclk, .aresetn, .sig_above_hi,
  .sig_above_lo, .pd_enable, .freq_locked, .sig_present, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
